/* File: hw/acs_ctrl.sv */
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`default_nettype none
`include "acs_regs.svh"

// Overview of operation
// - reference 000/1xx supply+ground, 001 ext plus, 010 ext minus, 011 both
// - offset calibration ties both sample-hold inputs to the low reference
// - without calibration, inputs follow channel and scan select registers
// - split mode fill bit reads 1 filling 0x8-0xF, 0 filling 0x0-0x7
// - interrupt after every Nth sequence, N equals rate field plus one
// - split bit gives two 8-word buffers, else one 16-word buffer
// - alternate bit: first sample A, then B, A alternately; else always A
// - upper sixteen bits and bits 11, 9, 8, 6 read as zero
module acs_ctrl
  import acs_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // converter result from the analog side
  input wire logic I_CONV_DONE,
  input wire logic [9:0] I_CONV_DATA,
  // reference and sample-hold routing
  output logic O_VREF_HI_EXT,
  output logic O_VREF_LO_EXT,
  output logic [4:0] O_SH_POS_CH,
  output logic O_SH_POS_LOW_REF,
  output logic O_SH_NEG_EXT,
  // status toward the system
  output logic O_FILL_HALF,
  output logic O_IRQ
);

  // register map, one aligned word each:
  //   0x00 control word, 0x04 event status (write one to clear)
  //   0x08 event mask of the same layout, 0x0C channel routing
  //   0x10 scan selection, 0x40 to 0x7C sixteen read-only results
  // reads insert one wait state so that hrdata leaves a flop;
  // writes insert none and land at the end of their data phase
  // a result counts three edges after its done level rises: two
  // synchroniser stages and one edge-detect stage
  // done must stay high and low for one clock at least, else a
  // short pulse may slip between two synchroniser samples
  // the result word passes two flops as well, so it must be steady
  // from the rise of done until the edge that stores it
  // writing the control word restarts counting, filling and scanning,
  // which keeps a half-finished sequence from mixing two setups
  acs_state_type s_reg;
  acs_state_type s_next;

  // scan order is ascending channel number; with no bit selected the
  // index stays where it is, so an empty selection simply holds still
  // next selected scan input after the current one, wrapping round
  function automatic logic [3:0] scan_step(input logic [3:0] idx,
                                           input logic [15:0] sel);
    logic [3:0] res;
    logic found;
    logic [3:0] cand;
    res = idx;
    found = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      cand = idx + k[3:0];
      if (!found && sel[cand]) begin
        res = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // control word as software sees it
  function automatic logic [31:0] ctrl_word(input acs_ctrl_type c,
                                            input logic fill);
    logic [31:0] w;
    w = 32'h0000_0000; // unimplemented bits stay zero
    w[`ACS_REF_HI:`ACS_REF_LO] = c.ref_sel;
    w[`ACS_OFFSET_CALIBRATION_ENABLE_BIT] = c.offset_calibration_enable;
    w[`ACS_SCAN_BIT] = c.scan_en;
    w[`ACS_FILL_BIT] = fill;
    w[`ACS_SEQUENCES_PER_INTERRUPT_HI:`ACS_SEQUENCES_PER_INTERRUPT_LO] = c.sequences_per_interrupt;
    w[`ACS_SPLIT_BIT] = c.split;
    w[`ACS_ALT_BIT] = c.alt;
    return w;
  endfunction

  logic bus_take;
  logic conv_edge;
  logic seq_last;
  logic half_full;
  logic ctrl_wr;
  logic [1:0] ev;
  logic [1:0] w1c;
  logic [31:0] rd_word;
  logic [4:0] a_pos;
  logic [4:0] sel_pos;
  logic sel_neg;
  logic [3:0] ph_idx;

  always_comb begin
    s_next = s_reg;
    ev = 2'h0;
    w1c = 2'h0;
    ctrl_wr = 1'b0;
    seq_last = 1'b0;
    half_full = 1'b0;
    rd_word = 32'h0000_0000;
    ph_idx = s_reg.ph_addr[3:0];
    // a transfer starts on nonseq or seq while the bus is ready
    bus_take = I_HSEL && I_HTRANS[1] && I_HREADY;
    // only the second stage feeds the edge detector
    conv_edge = s_reg.sync[1] && !s_reg.sync[2];

    // synchronise the converter's done level
    s_next.sync = {s_reg.sync[1], s_reg.sync[0], I_CONV_DONE};

    // the result word is synchronised alongside; word and done reach
    // their second stage together, so the stored word has settled
    s_next.dsync = {s_reg.dsync[0], I_CONV_DATA};

    // the read word is built from the registered phase address, one
    // cycle after the address phase, so a write just before is seen
    // read mux, unmapped words answer zero
    case ({s_reg.ph_addr, 2'b00})
      `ACS_OFS_CONTROL_TWO: rd_word = ctrl_word(s_reg.ctrl, s_reg.half);
      `ACS_OFS_STATUS: rd_word = {30'h0, s_reg.status};
      `ACS_OFS_MASK: rd_word = {30'h0, s_reg.mask};
      `ACS_OFS_CHANNEL_SELECT: rd_word = {16'h0000, s_reg.chsel};
      `ACS_OFS_SCAN_SELECT: rd_word = {16'h0000, s_reg.scansel};
      default: begin
        if ({s_reg.ph_addr[5:4], 6'h00} == `ACS_OFS_RESULT_BASE) begin
          rd_word = {22'h0, s_reg.rbuf[ph_idx]};
        end
      end
    endcase

    // the slave never stretches a write and never answers an error;
    // only the read path holds hready low, for exactly one cycle
    // data phase of an earlier address phase
    case (s_reg.bus)
      BUS_IDLE: begin
        s_next.hready = 1'b1;
      end
      BUS_WRITE: begin
        // hwdata is valid now, the edge ends the data phase
        case ({s_reg.ph_addr, 2'b00})
          `ACS_OFS_CONTROL_TWO: begin
            ctrl_wr = 1'b1;
            s_next.ctrl.ref_sel = I_HWDATA[`ACS_REF_HI:`ACS_REF_LO];
            s_next.ctrl.offset_calibration_enable = I_HWDATA[`ACS_OFFSET_CALIBRATION_ENABLE_BIT];
            s_next.ctrl.scan_en = I_HWDATA[`ACS_SCAN_BIT];
            s_next.ctrl.sequences_per_interrupt = I_HWDATA[`ACS_SEQUENCES_PER_INTERRUPT_HI:`ACS_SEQUENCES_PER_INTERRUPT_LO];
            s_next.ctrl.split = I_HWDATA[`ACS_SPLIT_BIT];
            s_next.ctrl.alt = I_HWDATA[`ACS_ALT_BIT];
          end
          `ACS_OFS_STATUS: w1c = I_HWDATA[1:0];
          `ACS_OFS_MASK: s_next.mask = I_HWDATA[1:0];
          `ACS_OFS_CHANNEL_SELECT: s_next.chsel = I_HWDATA[15:0];
          `ACS_OFS_SCAN_SELECT: s_next.scansel = I_HWDATA[15:0];
          default: begin
            // results are read-only, other words ignore writes
          end
        endcase
      end
      BUS_RD_WAIT: begin
        // one wait state lets hrdata come from a flop
        s_next.hrdata = rd_word;
        s_next.hready = 1'b1;
        s_next.bus = BUS_RD_DONE;
      end
      BUS_RD_DONE: begin
        s_next.hready = 1'b1;
      end
      default: begin
        s_next.bus = BUS_IDLE;
        s_next.hready = 1'b1;
      end
    endcase

    // a new address phase may overlap the data phase of a write;
    // the write above still lands, it decodes the registered phase
    // address phase, taken only while the bus is ready
    if (bus_take) begin
      s_next.ph_addr = I_HADDR[7:2];
      if (I_HWRITE) begin
        s_next.bus = BUS_WRITE;
      end else begin
        s_next.bus = BUS_RD_WAIT;
        s_next.hready = 1'b0;
      end
    end else if (s_reg.bus != BUS_RD_WAIT) begin
      s_next.bus = BUS_IDLE;
    end

    // counters, pointer and fill half move together on one done edge
    // so that software never sees a word stored in the wrong half
    // one finished sample/convert sequence
    if (conv_edge) begin
      s_next.rbuf[s_reg.wptr] = s_reg.dsync[1];
      seq_last = (s_reg.cnt == s_reg.ctrl.sequences_per_interrupt);
      half_full = s_reg.ctrl.split && (s_reg.wptr[2:0] == `ACS_HALF_LAST);
      if (seq_last) begin
        s_next.cnt = 4'h0; // N = rate field + 1
        ev[`ACS_EV_SEQ] = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 4'h1;
      end
      // in split mode an event also closes the half early, so the words
      // software reads always belong to one finished group
      if (s_reg.ctrl.split && (seq_last || half_full)) begin
        // switch halves so software reads the finished one
        s_next.half = !s_reg.half;
        s_next.wptr = {!s_reg.half, 3'h0};
        ev[`ACS_EV_HALF] = 1'b1;
      end else if (seq_last) begin
        // single 16-word buffer restarts at word zero
        s_next.wptr = s_reg.ctrl.split ? {s_reg.half, 3'h0} : 4'h0;
      end else begin
        s_next.wptr = s_reg.wptr + 4'h1;
      end
      // first sample uses A, then B and A take turns
      s_next.alt_b = s_reg.ctrl.alt ? !s_reg.alt_b : 1'b0;
      // advance the scan only on samples that used the A settings
      if (s_reg.ctrl.scan_en && !s_reg.alt_b) begin
        s_next.scan_idx = scan_step(s_reg.scan_idx, s_reg.scansel);
      end
    end

    // a done edge and a control write in one cycle: the write wins for
    // counters and pointer, the result of that edge still lands
    // a control write restarts the sequence from the top
    if (ctrl_wr) begin
      s_next.cnt = 4'h0;
      s_next.wptr = 4'h0;
      s_next.half = 1'b0;
      s_next.alt_b = 1'b0;
      s_next.scan_idx = 4'h0;
    end
    if (!s_next.ctrl.split) begin
      s_next.half = 1'b0; // no meaning outside split mode
    end

    // w1c holds the bits that software asked to clear in this cycle;
    // an event in the same cycle survives it and is seen next time
    // sticky events, a new event beats a same-cycle clear
    s_next.status = (s_reg.status & ~w1c) | ev;
    s_next.irq = |(s_next.status & s_next.mask);
    s_next.hresp = 1'b0;

    // the routing is worked out from the next state, so it changes on
    // the same edge as the control word or the alternation that drives it
    // reference decode, codes 1xx fall back to supply and ground
    case (s_next.ctrl.ref_sel)
      3'h1: begin
        s_next.front.vref_hi_ext = 1'b1;
        s_next.front.vref_lo_ext = 1'b0;
      end
      3'h2: begin
        s_next.front.vref_hi_ext = 1'b0;
        s_next.front.vref_lo_ext = 1'b1;
      end
      3'h3: begin
        s_next.front.vref_hi_ext = 1'b1;
        s_next.front.vref_lo_ext = 1'b1;
      end
      default: begin
        s_next.front.vref_hi_ext = 1'b0;
        s_next.front.vref_lo_ext = 1'b0;
      end
    endcase

    // scanning replaces the positive input of the A settings only;
    // the B settings always come straight from the routing register
    // choose the multiplexer settings for the coming sample
    if (s_next.ctrl.scan_en) begin
      a_pos = {1'b0, s_next.scan_idx}; // scanned input
    end else begin
      a_pos = s_next.chsel[`ACS_CHA_POS_HI:0];
    end
    if (s_next.ctrl.alt && s_next.alt_b) begin
      sel_pos = s_next.chsel[`ACS_CHB_POS_HI:`ACS_CHB_POS_LO];
      sel_neg = s_next.chsel[`ACS_CHB_NEG_BIT];
    end else begin
      sel_pos = a_pos;
      sel_neg = s_next.chsel[`ACS_CHA_NEG_BIT];
    end

    // under calibration the channel number is parked at zero; it has no
    // meaning then, and a fixed value keeps the analog mux from toggling
    // calibration overrides routing, both inputs on the low reference
    if (s_next.ctrl.offset_calibration_enable) begin
      s_next.front.pos_ch = 5'h00;
      s_next.front.pos_lo = 1'b1;
      s_next.front.neg_ext = 1'b0;
    end else begin
      s_next.front.pos_ch = sel_pos;
      s_next.front.pos_lo = 1'b0;
      s_next.front.neg_ext = sel_neg;
    end
  end

  // the reset branch loads constants only; the struct defaults first
  // and the few fields with their own reset value follow
  // single state register, async reset to constants only
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_reg <= '0;
      s_reg.hready <= 1'b1;
      s_reg.ctrl <= acs_ctrl_type'(`ACS_CTRL_RST);
      s_reg.chsel <= `ACS_CHSEL_RST;
      s_reg.scansel <= `ACS_SCAN_RST;
      s_reg.status <= `ACS_EV_RST;
      s_reg.mask <= `ACS_EV_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // no output is decoded combinationally, so none can glitch
  // every output straight from the state flops
  assign O_HRDATA = s_reg.hrdata;
  assign O_HREADYOUT = s_reg.hready;
  assign O_HRESP = s_reg.hresp;
  assign O_VREF_HI_EXT = s_reg.front.vref_hi_ext;
  assign O_VREF_LO_EXT = s_reg.front.vref_lo_ext;
  assign O_SH_POS_CH = s_reg.front.pos_ch;
  assign O_SH_POS_LOW_REF = s_reg.front.pos_lo;
  assign O_SH_NEG_EXT = s_reg.front.neg_ext;
  assign O_FILL_HALF = s_reg.half;
  assign O_IRQ = s_reg.irq;

endmodule

`default_nettype wire

/* File: hw/acs_pkg.sv */
`default_nettype none

package acs_pkg;

  // bus slave phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } acs_bus_type;

  // software-written control fields
  typedef struct packed {
    logic [2:0] ref_sel;
    logic offset_calibration_enable;
    logic scan_en;
    logic [3:0] sequences_per_interrupt;
    logic split;
    logic alt;
  } acs_ctrl_type;

  // drive toward the analog front end
  typedef struct packed {
    logic vref_hi_ext;
    logic vref_lo_ext;
    logic [4:0] pos_ch;
    logic pos_lo;
    logic neg_ext;
  } acs_front_type;

  // whole state of the block
  typedef struct packed {
    acs_bus_type bus;
    logic [5:0] ph_addr;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    acs_ctrl_type ctrl;
    logic [15:0] chsel;
    logic [15:0] scansel;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic [2:0] sync;
    logic [1:0][9:0] dsync;
    logic [3:0] cnt;
    logic [3:0] wptr;
    logic half;
    logic alt_b;
    logic [3:0] scan_idx;
    logic [15:0][9:0] rbuf;
    acs_front_type front;
  } acs_state_type;

endpackage

`default_nettype wire

/* File: hw/acs_regs.svh */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// register byte offsets
`define ACS_OFS_CONTROL_TWO 8'h00
`define ACS_OFS_STATUS 8'h04
`define ACS_OFS_MASK 8'h08
`define ACS_OFS_CHANNEL_SELECT 8'h0C
`define ACS_OFS_SCAN_SELECT 8'h10
`define ACS_OFS_RESULT_BASE 8'h40

// adc_control_two field positions
`define ACS_REF_HI 15
`define ACS_REF_LO 13
`define ACS_OFFSET_CALIBRATION_ENABLE_BIT 12
`define ACS_SCAN_BIT 10
`define ACS_FILL_BIT 7
`define ACS_SEQUENCES_PER_INTERRUPT_HI 5
`define ACS_SEQUENCES_PER_INTERRUPT_LO 2
`define ACS_SPLIT_BIT 1
`define ACS_ALT_BIT 0

// channel_select_register fields
`define ACS_CHA_POS_HI 4
`define ACS_CHA_NEG_BIT 7
`define ACS_CHB_POS_HI 12
`define ACS_CHB_POS_LO 8
`define ACS_CHB_NEG_BIT 15

// status and mask bits
`define ACS_EV_SEQ 0
`define ACS_EV_HALF 1

// reset values
`define ACS_CTRL_RST 11'h000
`define ACS_CHSEL_RST 16'h0000
`define ACS_SCAN_RST 16'h0000
`define ACS_EV_RST 2'h0

// buffer geometry
`define ACS_HALF_LAST 3'h7

`endif

/* File: tb/acs_analog_model.sv */
`default_nettype none
module acs_analog_model (
  // demand and routing
  input wire logic clk,
  input wire logic [7:0] i_want,
  input wire logic [7:0] i_gap,
  input wire logic [9:0] i_route,
  // result toward the block
  output logic o_done,
  output logic [9:0] o_data,
  output logic [7:0] o_made
);
  timeunit 1ns;
  timeprecision 1ps;
  // one result per sequence; the word echoes the routing when sampled
  initial begin
    o_done = 1'b0;
    o_data = 10'h3FF;
    o_made = 8'h00;
    forever begin
      @(posedge clk);
      if (o_made != i_want) begin
        o_data <= i_route;
        o_done <= 1'b1;
        repeat (4) @(posedge clk);
        o_done <= 1'b0;
        o_data <= ~i_route; // a stale word must not look valid
        repeat (i_gap) @(posedge clk);
        o_made <= o_made + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/acs_ctrl_properties.sv */
`default_nettype none
module acs_ctrl_properties (
  // bus
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic O_HREADYOUT,
  // converter
  input wire logic I_CONV_DONE,
  input wire logic O_VREF_HI_EXT,
  input wire logic O_VREF_LO_EXT,
  input wire logic [4:0] O_SH_POS_CH,
  input wire logic O_SH_POS_LOW_REF,
  input wire logic O_SH_NEG_EXT,
  input wire logic O_FILL_HALF,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take, wph, q5;
  logic [15:0] sh;
  logic [2:0] quiet;
  logic [2:0] rs;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  // q5 marks a control word left alone long enough to have settled
  assign take = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign q5 = quiet == 3'h5;
  assign rs = sh[15:13];
  // shadow of the control word, rebuilt from bus writes
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wph <= 1'b0;
      sh <= 16'h0000;
      quiet <= 3'h0;
    end else begin
      if (take) begin
        wph <= I_HWRITE && I_HADDR[7:2] == 6'h00;
      end else if (I_HREADY) begin
        wph <= 1'b0;
      end
      if (wph && I_HREADY) begin
        sh <= I_HWDATA[15:0];
        quiet <= 3'h0;
      end else if (!q5) begin
        quiet <= quiet + 3'h1;
      end
    end
  end
  property p_vref;
    q5 |-> O_VREF_HI_EXT == (rs == 3'h1 || rs == 3'h3)
      && O_VREF_LO_EXT == (rs == 3'h2 || rs == 3'h3);
  endproperty
  a_vref: assert property (p_vref) else $error("bad reference");
  property p_cal;
    q5 && sh[12] |-> O_SH_POS_LOW_REF;
  endproperty
  a_cal: assert property (p_cal) else $error("no calibration");
  property p_calch;
    O_SH_POS_LOW_REF |-> O_SH_POS_CH == 5'h00 && !O_SH_NEG_EXT;
  endproperty
  a_calch: assert property (p_calch) else $error("cal inputs");
  property p_nocal;
    q5 && !sh[12] |-> !O_SH_POS_LOW_REF;
  endproperty
  a_nocal: assert property (p_nocal) else $error("stray cal");
  property p_single;
    q5 && !sh[1] |-> !O_FILL_HALF;
  endproperty
  a_single: assert property (p_single) else $error("fill set");
  property p_fill;
    $rose(O_FILL_HALF) |-> sh[1] && $past(I_CONV_DONE, 3);
  endproperty
  a_fill: assert property (p_fill) else $error("fill rose");
  property p_irq;
    $rose(O_IRQ) |-> $past(I_CONV_DONE, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("irq cause");
  property p_rdwait;
    take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT;
  endproperty
  a_rdwait: assert property (p_rdwait) else $error("read wait");
endmodule
bind acs_ctrl acs_ctrl_properties i_props (.I_CLK, .I_RST_B, .I_HSEL,
  .I_HADDR, .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .O_HREADYOUT,
  .I_CONV_DONE, .O_VREF_HI_EXT, .O_VREF_LO_EXT, .O_SH_POS_CH,
  .O_SH_POS_LOW_REF, .O_SH_NEG_EXT, .O_FILL_HALF, .O_IRQ);
`default_nettype wire

/* File: tb/acs_ctrl_tb_top.sv */
`default_nettype none
module acs_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwr = 1'b0;
  logic [1:0] htr = 2'h0;
  logic [31:0] hadr = 32'h0;
  logic [31:0] hwd = 32'h0;
  logic [31:0] hrd;
  logic hrdy, hresp, done, hi, lo, lref, nx, fill, irq;
  logic [4:0] pch;
  logic [9:0] cdat;
  logic [7:0] want = 8'h00;
  logic [7:0] gap = 8'h04;
  logic [7:0] made;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  acs_ctrl i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_HSEL(hsel),
    .I_HADDR(hadr), .I_HTRANS(htr), .I_HWRITE(hwr), .I_HSIZE(3'h2),
    .I_HWDATA(hwd), .I_HREADY(hrdy), .O_HRDATA(hrd), .O_HREADYOUT(hrdy),
    .O_HRESP(hresp), .I_CONV_DONE(done), .I_CONV_DATA(cdat),
    .O_VREF_HI_EXT(hi), .O_VREF_LO_EXT(lo), .O_SH_POS_CH(pch),
    .O_SH_POS_LOW_REF(lref), .O_SH_NEG_EXT(nx), .O_FILL_HALF(fill),
    .O_IRQ(irq));
  acs_analog_model i_far (.clk(clk), .i_want(want), .i_gap(gap),
    .i_route({lref, nx, hi, lo, 1'b0, pch}), .o_done(done),
    .o_data(cdat), .o_made(made));
  // one single-word transfer, waiting on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htr <= 2'h2;
    hadr <= {24'h0, a};
    hwr <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrd;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("read", q, e);
    chk("resp", 32'(hresp), 32'h0);
  endtask
  // ask the far side for n sequences and wait for them to land
  task automatic run(input logic [7:0] n);
    want <= want + n;
    @(posedge clk);
    while (made !== want) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  task automatic summarize;
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0);
    rdc(8'h20, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'hFFFFFFFF);
    rdc(8'h00, 32'h0000F43F);
    // every reference code, judged by the checker once settled
    for (i = 0; i < 8; i++) begin
      wr(8'h00, 32'(i) << 13);
      repeat (6) @(posedge clk);
    end
    wr(8'h0C, 32'h0985);
    wr(8'h00, 32'h1000);
    repeat (6) @(posedge clk);
    chk("cal", 32'({lref, nx, pch}), 32'h40);
    wr(8'h00, 32'h0);
    repeat (6) @(posedge clk);
    chk("route", 32'({lref, nx, pch}), 32'h25);
    wr(8'h00, 32'h000D);
    run(8'd4);
    chk("irq", 32'(irq), 32'h1);
    for (i = 0; i < 4; i++) begin
      rdc(8'h40 + 8'(4 * i), i[0] ? 32'h009 : 32'h105);
    end
    wr(8'h04, 32'h3);
    wr(8'h10, 32'h9);
    wr(8'h00, 32'h040C);
    run(8'd3);
    chk("irq", 32'(irq), 32'h0);
    run(8'd1);
    chk("irq", 32'(irq), 32'h1);
    for (i = 0; i < 4; i++) begin
      rdc(8'h40 + 8'(4 * i), i[0] ? 32'h103 : 32'h100);
    end
    gap <= 8'd20;
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h001E);
    run(8'd7);
    chk("fill", 32'(fill), 32'h0);
    run(8'd1);
    chk("fill", 32'(fill), 32'h1);
    rdc(8'h00, 32'h009E);
    run(8'd8);
    chk("fill", 32'(fill), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
